/* File: logic/host_ports_defines.vh */
// constants for the host slave port block
// assumes a single 100 MHz core clock domain
`ifndef HOST_PORTS_DEFINES_VH
`define HOST_PORTS_DEFINES_VH

// port selects in address bits 2..0 (offsets 7, 5, 3 from base)
`define PORT_A_SEL        3'h7
`define PORT_B_SEL        3'h5
`define PORT_C_SEL        3'h3
// local i/o addresses (byte)
`define LOC_STATUS_ADDR   8'hF0
`define LOC_HOST_DATA     8'hE8
`define LOC_HOST_IRQ      8'hB8
// status byte 0 bits
`define SB0_DIAG_BIT      0
`define SB0_HIRQ_BIT      1
`define SB0_LIRQ_BIT      3
`define SB0_LOOP_BIT      6
// local status word bits
`define LSW_MEM_BIT       1
`define LSW_LOW_RESET     8'h00
// status byte 0 after reset: only bit 3 set
`define SB0_RESET         8'h08
`define AM_RESET          6'h00
`define AM_WIDTH          6
// base presets for address bits 15..8 and 7
`define BASE0_HI          8'h00
`define BASE1_HI          8'h7F
`define BASE2_HI          8'h80
`define BASE3_HI          8'hFF
`define BASE0_B7          1'b0
`define BASE1_B7          1'b1
`define BASE2_B7          1'b0
`define BASE3_B7          1'b1
// board reset pulse length in cycles
`define BOARD_RST_CYCLES  4'h8

`endif

/* File: logic/sync2.v */
// two flip-flop synchroniser, WIDTH bits per instance
// assumes inputs come from pins outside the core_clk domain
`timescale 1ns/1ps
module sync2 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             core_clk,
	input  wire             srst,
	// data
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1;

	// first stage feeds only the second stage
	always @(posedge core_clk) begin
		if (srst) begin
			stage1 <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // sync2

/* File: logic/host_ports.v */
// host slave ports: decode, status bytes, doorbell, address modifier
// assumes host strobes arrive from the backplane; local bus is on core_clk
`timescale 1ns/1ps
`include "host_ports_defines.vh"
module host_ports (
	// clock and reset
	input  wire        core_clk,
	input  wire        srst,
	// host bus (pins, active low strobes)
	input  wire [31:1] host_addr,
	input  wire        host_as_n,
	input  wire        host_ds0_n,
	input  wire        host_write_n,
	input  wire [7:0]  host_wdata,
	output reg  [7:0]  host_rdata,
	output reg         host_dtack_n,
	input  wire        host_iack_n,
	input  wire        host_iackin_n,
	output wire        host_iackout_n,
	input  wire [2:0]  host_iack_level,
	output wire        host_irq_n,
	// configuration jumpers (pins)
	input  wire [15:0] compare_jumper,
	input  wire        base_select_jumper_hi,
	input  wire        base_select_jumper_lo,
	input  wire        master_width_jumper,
	input  wire        slave_width_jumper,
	input  wire        ack_level_select_b2,
	input  wire        ack_level_select_b1,
	input  wire        ack_level_select_b0,
	// local processor i/o
	input  wire [7:0]  loc_addr,
	input  wire        loc_wr,
	input  wire        loc_rd,
	input  wire [15:0] loc_wdata,
	output reg  [7:0]  loc_rdata,
	// outputs to the board
	output wire        local_irq_input_one,
	output wire        upper_ram_enable,
	output wire        board_reset,
	output wire        master_am_valid,
	output reg  [5:0]  master_am
);
	// synchronised host pins
	wire [31:1] addr_s;
	wire [7:0]  wdata_s;
	wire [2:0]  iack_lvl_s;
	wire        as_s;
	wire        ds_s;
	wire        wr_s;
	wire        iack_s;
	wire        iackin_s;
	wire [15:0] cmp_s;
	wire [7:0]  cfg_s;
	sync2 #(.WIDTH(31 + 8 + 3 + 5 + 16 + 8)) u_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.async_in ({host_addr, host_wdata, host_iack_level, ~host_as_n, ~host_ds0_n,
			~host_write_n, ~host_iack_n, ~host_iackin_n, compare_jumper,
			base_select_jumper_hi, base_select_jumper_lo, master_width_jumper,
			slave_width_jumper, ack_level_select_b2, ack_level_select_b1,
			ack_level_select_b0, 1'b0}),
		.sync_out ({addr_s, wdata_s, iack_lvl_s, as_s, ds_s, wr_s, iack_s, iackin_s,
			cmp_s, cfg_s})
	);

	wire       sel_hi   = cfg_s[7];
	wire       sel_lo   = cfg_s[6];
	wire       m32      = ~cfg_s[5];
	wire       s32      = ~cfg_s[4];
	wire [2:0] ack_lvl  = cfg_s[3:1];

	// state
	reg [15:0] status_word;
	reg        host_irq_flag;
	reg        local_irq_flag;
	reg [7:0]  host_data;
	reg        cycle_done;
	reg        ack_done;
	reg [3:0]  rst_count;

	// address decode
	reg [7:0] base_hi;
	reg       base_b7;
	always @* begin
		if (sel_hi && sel_lo) begin
			base_hi = `BASE3_HI;
			base_b7 = `BASE3_B7;
		end else if (sel_hi) begin
			base_hi = `BASE2_HI;
			base_b7 = `BASE2_B7;
		end else if (sel_lo) begin
			base_hi = `BASE1_HI;
			base_b7 = `BASE1_B7;
		end else begin
			base_hi = `BASE0_HI;
			base_b7 = `BASE0_B7;
		end
	end

	// installed jumper reads 0 and demands a 0 address bit
	wire [15:0] hi_match = ~(addr_s[31:16] ^ cmp_s);
	wire        top_ok   = s32 ? &hi_match : &hi_match[7:0];
	// bits 6..3 deliberately not compared
	wire        low_ok   = (addr_s[15:8] == base_hi) && (addr_s[7] == base_b7);
	wire        hit      = as_s && ds_s && !iack_s && top_ok && low_ok;
	wire [2:0]  port     = {addr_s[2:1], 1'b1};
	wire        is_a     = hit && (port == `PORT_A_SEL);
	wire        is_b     = hit && (port == `PORT_B_SEL);
	wire        is_c     = hit && (port == `PORT_C_SEL) && wr_s;
	wire        start    = (is_a || is_b || is_c) && !cycle_done;

	// interrupt acknowledge on our level only; ack_done keeps the chain
	// blocked after the flag clears, or the ack would leak downstream
	wire        ack_ours = as_s && iack_s && iackin_s && (host_irq_flag || ack_done)
		&& (iack_lvl_s == ack_lvl);
	wire        ack_take = ack_ours && !ack_done;
	// daisy chain passes through when not ours
	assign host_iackout_n = ~(iackin_s && !ack_ours);
	assign host_irq_n     = ~host_irq_flag;

	// local strobes
	wire loc_status_wr = loc_wr && (loc_addr == `LOC_STATUS_ADDR);
	wire loc_hirq_wr   = loc_wr && (loc_addr == `LOC_HOST_IRQ);
	wire loc_data_rd   = loc_rd && (loc_addr == `LOC_HOST_DATA);
	wire host_b_wr     = start && is_b && wr_s;
	wire host_a_wr     = start && is_a && wr_s;

	// status byte 0 assembly; bit 3 of the word is never used
	wire [7:0] status_b0 = {status_word[7], status_word[`SB0_LOOP_BIT],
		status_word[5:4], local_irq_flag, status_word[2],
		host_irq_flag, status_word[`SB0_DIAG_BIT]};

	always @(posedge core_clk) begin
		if (srst) begin
			// high byte kept over reset; it is undefined at power up
			status_word[7:0] <= `LSW_LOW_RESET;
			host_irq_flag    <= 1'b0;
			local_irq_flag   <= 1'b1;
			cycle_done       <= 1'b0;
			ack_done         <= 1'b0;
			host_dtack_n     <= 1'b1;
			host_rdata       <= 8'h00;
			master_am        <= `AM_RESET;
			loc_rdata        <= 8'h00;
			rst_count        <= 4'h0;
		end else begin
			if (loc_status_wr)
				status_word <= loc_wdata;
			// set wins over clear on both flags
			if (loc_hirq_wr)
				host_irq_flag <= 1'b1;
			else if (ack_take)
				host_irq_flag <= 1'b0;
			if (host_b_wr)
				local_irq_flag <= 1'b1;
			else if (loc_data_rd)
				local_irq_flag <= 1'b0;
			if (start && is_c)
				master_am <= wdata_s[`AM_WIDTH-1:0];
			if (start && !wr_s)
				host_rdata <= is_a ? status_word[15:8] : status_b0;
			if (ack_take)
				host_rdata <= {5'h00, ack_lvl};
			if (loc_data_rd)
				loc_rdata <= host_data;
			// hold dtack until the strobe goes away
			if (start || ack_take) begin
				cycle_done   <= start;
				ack_done     <= ack_take;
				host_dtack_n <= 1'b0;
			end else if (!as_s) begin
				cycle_done   <= 1'b0;
				ack_done     <= 1'b0;
				host_dtack_n <= 1'b1;
			end
			if (host_a_wr)
				rst_count <= `BOARD_RST_CYCLES;
			else if (rst_count != 4'h0)
				rst_count <= rst_count - 4'h1;
		end
	end

	// host data register survives reset so a late read still sees it
	always @(posedge core_clk) begin
		if (host_b_wr)
			host_data <= wdata_s;
	end

	assign local_irq_input_one = local_irq_flag;
	assign upper_ram_enable    = status_word[`LSW_MEM_BIT];
	// board reset is fed back as srst by the surrounding board logic
	assign board_reset         = (rst_count != 4'h0);
	assign master_am_valid     = m32;
endmodule // host_ports

/* File: tb/host_master.sv */
// host bus master model: single byte cycles and interrupt acknowledge
// assumes the adapter answers with host_dtack_n sampled on core_clk
`timescale 1ns/1ps
module host_master (
	// clock
	input  wire        core_clk,
	// host bus
	output reg  [31:1] host_addr,
	output reg         host_as_n,
	output reg         host_ds0_n,
	output reg         host_write_n,
	output reg  [7:0]  host_wdata,
	output reg         host_iack_n,
	output reg  [2:0]  host_iack_level,
	input  wire [7:0]  host_rdata,
	input  wire        host_dtack_n
);
	initial begin
		host_addr = 31'h0;
		host_as_n = 1'h1;
		host_ds0_n = 1'h1;
		host_write_n = 1'h1;
		host_wdata = 8'h00;
		host_iack_n = 1'h1;
		host_iack_level = 3'h0;
	end
	// rd=1 reads; ak=1 makes it an acknowledge at level a[3:1]
	task cycle(input [31:0] a, input rd, input [7:0] d, input ak,
		output [7:0] q, output ok);
		integer n;
		begin
			@(posedge core_clk) #1;
			host_addr = a[31:1];
			host_iack_level = a[3:1];
			host_write_n = rd;
			host_wdata = d;
			host_iack_n = ~ak;
			host_as_n = 1'h0;
			host_ds0_n = 1'h0;
			n = 0;
			while (host_dtack_n !== 1'h0 && n < 12) begin
				@(posedge core_clk) #1;
				n = n + 1;
			end
			ok = (host_dtack_n === 1'h0);
			q = host_rdata;
			@(posedge core_clk) #1;
			host_as_n = 1'h1;
			host_ds0_n = 1'h1;
			host_iack_n = 1'h1;
			// released lines stop showing the last value
			host_addr = ~host_addr;
			host_wdata = ~host_wdata;
			n = 0;
			while (host_dtack_n !== 1'h1 && n < 12) begin
				@(posedge core_clk) #1;
				n = n + 1;
			end
		end
	endtask
endmodule // host_master

/* File: tb/host_ports_assertions.sv */
// pin-level checks of host_ports
// assumes one core_clk domain and synchronous active-high srst
`timescale 1ns/1ps
module host_ports_assertions (
	input wire        core_clk,
	input wire        srst,
	input wire [31:1] host_addr,
	input wire        host_as_n,
	input wire        host_write_n,
	input wire [7:0]  host_wdata,
	input wire        host_dtack_n,
	input wire        host_iack_n,
	input wire        host_irq_n,
	input wire [7:0]  loc_addr,
	input wire        loc_wr,
	input wire        loc_rd,
	input wire [15:0] loc_wdata,
	input wire        local_irq_input_one,
	input wire        upper_ram_enable,
	input wire        board_reset,
	input wire [5:0]  master_am
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_c_read_refused: assert property (!host_as_n && host_write_n && host_iack_n
		&& host_addr[2:1] == 2'h1 |-> host_dtack_n) else $error("port C read answered");
	a_ram_gate_bit: assert property (loc_wr && loc_addr == 8'hF0
		|=> upper_ram_enable == $past(loc_wdata[1])) else $error("ram gate wrong");
	a_board_pulse_len: assert property ($rose(board_reset)
		|-> board_reset[*8] ##1 !board_reset) else $error("board reset length");
	a_port_a_reset: assert property ($fell(host_dtack_n) && !host_write_n
		&& host_iack_n && host_addr[2:1] == 2'h3 |-> ##[0:2] board_reset)
		else $error("no board reset");
	a_modifier_load: assert property ($fell(host_dtack_n) && !host_write_n
		&& host_iack_n && host_addr[2:1] == 2'h1 |-> master_am == host_wdata[5:0])
		else $error("modifier not loaded");
	a_strobe_host_irq: assert property (loc_wr && loc_addr == 8'hB8
		|=> !host_irq_n) else $error("host irq not raised");
	a_ack_clears_irq: assert property ($fell(host_dtack_n) && !host_iack_n
		|-> ##[0:1] host_irq_n) else $error("irq not cleared by ack");
	a_read_clears_lirq: assert property (loc_rd && loc_addr == 8'hE8 && host_as_n
		|=> !local_irq_input_one) else $error("local irq not cleared");
	c_board_reset: cover property ($rose(board_reset));
	c_ack_answer: cover property ($fell(host_dtack_n) && !host_iack_n);
	c_strobe: cover property (loc_wr && loc_addr == 8'hB8);
endmodule // host_ports_assertions
bind host_ports host_ports_assertions u_chk (.*);

/* File: tb/tb.sv */
// self-checking bench for host_ports
// assumes host_master on the host pins; local side driven here
`timescale 1ns/1ps
module tb;
	reg         core_clk, srst, loc_wr, loc_rd, ak, seen, fwd;
	reg         master_width_jumper, slave_width_jumper;
	reg  [7:0]  loc_addr, q;
	reg  [15:0] loc_wdata, compare_jumper;
	integer     bad_count, checked;
	wire [31:1] host_addr;
	wire [7:0]  host_wdata, host_rdata, loc_rdata;
	wire [5:0]  master_am;
	wire [2:0]  host_iack_level;
	wire        host_as_n, host_ds0_n, host_write_n, host_dtack_n, host_iack_n;
	wire        host_iackout_n, host_irq_n, local_irq_input_one;
	wire        upper_ram_enable, board_reset, master_am_valid;
	localparam [31:0] pa = 32'h00FF0007, pb = 32'h00FF0005, pc = 32'h00FF0003;
	host_master u_host (.*);
	host_ports u_dut (.*, .host_iackin_n(host_iack_n), .base_select_jumper_hi(1'h0),
		.base_select_jumper_lo(1'h0), .ack_level_select_b2(1'h0),
		.ack_level_select_b1(1'h1), .ack_level_select_b0(1'h1));
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (board_reset === 1'h1) seen <= 1'h1;
	always @(posedge core_clk) if (host_iackout_n === 1'h0) fwd <= 1'h1;
	task chk(input [7:0] g, input [7:0] e);
		begin
			checked = checked + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task hc(input [31:0] a, input rd, input [7:0] d, input eok, input [7:0] e);
		reg [7:0] r;
		reg       ok;
		begin
			u_host.cycle(a, rd, d, ak, r, ok);
			chk({7'h00, ok}, {7'h00, eok});
			if (rd && eok) chk(r, e);
		end
	endtask
	task lw(input [7:0] a, input [15:0] d);
		begin
			@(posedge core_clk) #1;
			loc_addr = a;
			loc_wdata = d;
			loc_wr = 1'h1;
			@(posedge core_clk) #1;
			loc_wr = 1'h0;
		end
	endtask
	task lr;
		begin
			@(posedge core_clk) #1;
			loc_addr = 8'hE8;
			loc_rd = 1'h1;
			@(posedge core_clk) #1;
			loc_rd = 1'h0;
			q = loc_rdata;
		end
	endtask
	task close_out;
		begin
			$display("checked %0d bad_count %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		#100000;
		bad_count = bad_count + 1;
		close_out;
	end
	initial begin
		{fwd, srst, loc_wr, loc_rd, ak, seen, master_width_jumper, slave_width_jumper} = 8'h40;
		{loc_addr, loc_wdata, compare_jumper} = {8'h00, 16'h0000, 16'h00FF};
		bad_count = 0;
		checked = 0;
		repeat (8) @(posedge core_clk);
		#1 srst = 1'h0;
		repeat (3) @(posedge core_clk);
		hc(pb, 1, 0, 1, 8'h08);
		chk({7'h00, host_irq_n}, 8'h01);
		lr;
		hc(pb, 1, 0, 1, 8'h00);
		chk({7'h00, local_irq_input_one}, 8'h00);
		$display("test reset done");
		lw(8'hF0, 16'hA541);
		hc(pa, 1, 0, 1, 8'hA5);
		hc(pb, 1, 0, 1, 8'h41);
		chk({7'h00, upper_ram_enable}, 8'h00);
		lw(8'hF0, 16'h5A0A);
		chk({7'h00, upper_ram_enable}, 8'h01);
		hc(pb, 1, 0, 1, 8'h00);
		$display("test status done");
		hc(pb, 0, 8'h3C, 1, 0);
		chk({7'h00, local_irq_input_one}, 8'h01);
		hc(pb, 1, 0, 1, 8'h08);
		lr;
		chk(q, 8'h3C);
		lw(8'hB8, 16'h0000);
		chk({7'h00, host_irq_n}, 8'h00);
		hc(pb, 1, 0, 1, 8'h02);
		ak = 1'h1;
		hc(32'h0000000A, 1, 0, 0, 0);
		chk({7'h00, fwd}, 8'h01);
		repeat (3) @(posedge core_clk);
		#1 fwd = 1'h0;
		hc(32'h00000006, 1, 0, 1, 8'h03);
		chk({7'h00, fwd}, 8'h00);
		ak = 1'h0;
		chk({7'h00, host_irq_n}, 8'h01);
		$display("test doorbell done");
		hc(pc, 0, 8'hFF, 1, 0);
		chk({2'h0, master_am}, 8'h3F);
		chk({7'h00, master_am_valid}, 8'h01);
		hc(pc, 1, 0, 0, 0);
		hc(32'h00FF8005, 1, 0, 0, 0);
		hc(32'h00FF0075, 1, 0, 1, 8'h00);
		hc(32'h01FF0005, 1, 0, 0, 0);
		slave_width_jumper = 1'h1;
		hc(32'h01FF0005, 1, 0, 1, 8'h00);
		hc(32'h00FE0005, 1, 0, 0, 0);
		master_width_jumper = 1'h1;
		repeat (3) @(posedge core_clk);
		chk({7'h00, master_am_valid}, 8'h00);
		$display("test decode done");
		hc(pa, 0, 8'h00, 1, 0);
		repeat (12) @(posedge core_clk);
		chk({7'h00, seen}, 8'h01);
		$display("test board reset done");
		close_out;
	end
endmodule // tb
